/* File: rtl/ads_sequencer.sv */
// Purpose: converter result sequencer writing words into data memory
// Assumes: converter done strobes are one-cycle pulses, synchronous
// Notes: a small fifo decouples the sequencer from memory back-pressure
`default_nettype none

// ****************************************
// fifo
// ****************************************
module ads_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr;
	logic [AW:0] rd;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
	assign empty = (wr == rd);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd[AW-1:0]];
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr <= '0;
		end else if (push) begin
			wr <= wr + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd <= '0;
		end else if (pop) begin
			rd <= rd + 1'b1;
		end
	end

	// pointer distance is taken modulo the pointer width, so wrap is harmless
	fifo_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(AW+1)'(wr - rd) <= DEPTH)
		else $error("fifo holds more than its depth");
endmodule

// ****************************************
// sequencer top
// ****************************************
module ads_sequencer #(
	parameter int DEPTH = ads_pkg::STORE_DEPTH,
	parameter int BUF_DEPTH = ads_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ptr_wr_i,
	input wire logic [ads_pkg::PTR_W-1:0] ptr_data_i,
	output logic [ads_pkg::PTR_W-1:0] instr_write_pointer_o,
	input wire logic port_wr_i,
	input wire logic port_rd_i,
	input wire logic [ads_pkg::INSTR_W-1:0] port_wdata_i,
	output logic [ads_pkg::INSTR_W-1:0] port_rdata_o,
	input wire logic enable_i,
	input wire logic [ads_pkg::ADDR_W-1:0] start_addr_i,
	input wire logic first_done_i,
	input wire logic [ads_pkg::DATA_W-1:0] first_result_i,
	input wire logic second_done_i,
	input wire logic [ads_pkg::DATA_W-1:0] second_result_i,
	output logic first_claim_o,
	output logic second_claim_o,
	output logic busy_o,
	output logic done_o,
	output logic mem_valid_o,
	input wire logic mem_ready_i,
	output logic [ads_pkg::ADDR_W-1:0] mem_addr_o,
	output logic [ads_pkg::DATA_W-1:0] mem_data_o
);
	localparam int WW = $bits(ads_pkg::ads_word_type);

	// decoding used by the executer and by the checks
	function automatic ads_pkg::ads_dec_type decode(
		input logic [ads_pkg::INSTR_W-1:0] code
	);
		ads_pkg::ads_dec_type d;
		d.eoo = (code[ads_pkg::BIT_DIFF:ads_pkg::BIT_FIRST]
			== ads_pkg::REQ_NONE);
		d.cont = code[ads_pkg::BIT_CONT];
		d.want0 = code[ads_pkg::BIT_FIRST] || code[ads_pkg::BIT_DIFF];
		d.want1 = code[ads_pkg::BIT_SECOND];
		d.two = d.want0 && d.want1;
		return d;
	endfunction

	// ****************************************
	// instruction store and pointer
	// ****************************************
	// sixty-four byte store
	logic [ads_pkg::INSTR_W-1:0] store [DEPTH];
	logic [ads_pkg::PTR_W-1:0] wptr;
	logic [ads_pkg::INSTR_W-1:0] rdata;
	logic port_access;

	assign port_access = port_wr_i || port_rd_i;
	assign instr_write_pointer_o = wptr;
	assign port_rdata_o = rdata;

	always_ff @(posedge clk_i) begin
		if (port_wr_i) begin
			store[wptr] <= port_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata <= ads_pkg::INSTR_RESET;
		end else if (port_rd_i) begin
			rdata <= store[wptr];
		end
	end

	// six-bit wrap is natural overflow; a direct load wins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr <= ads_pkg::PTR_RESET;
		end else if (ptr_wr_i) begin
			wptr <= ptr_data_i;
		end else if (port_access) begin
			wptr <= wptr + ads_pkg::PTR_STEP;
		end
	end

	// ****************************************
	// execution state
	// ****************************************
	ads_pkg::ads_state_type state;
	ads_pkg::ads_state_type next_state;
	logic [ads_pkg::PTR_W-1:0] ip;
	logic [ads_pkg::INSTR_W-1:0] instr;
	logic [ads_pkg::ADDR_W-1:0] dest;
	logic [ads_pkg::DATA_W-1:0] res0;
	logic [ads_pkg::DATA_W-1:0] res1;
	logic cap0;
	logic cap1;
	ads_pkg::ads_dec_type dec;
	logic have_all;
	logic push;
	logic in_ready;
	logic accepted;
	logic finish;
	ads_pkg::ads_word_type word;
	ads_pkg::ads_word_type out_word;

	assign dec = decode(instr);
	assign have_all = (cap0 || !dec.want0) && (cap1 || !dec.want1);
	// one word per WORD state, two or four bytes per transfer instruction, none for an end code
	assign push = (state == ads_pkg::ST_WORD1)
		|| (state == ads_pkg::ST_WORD2);
	assign accepted = push && in_ready;
	assign finish = accepted
		&& ((state == ads_pkg::ST_WORD2) || !dec.two);
	assign busy_o = (state != ads_pkg::ST_IDLE)
		&& (state != ads_pkg::ST_DONE);
	assign done_o = (state == ads_pkg::ST_DONE);
	// claims while in WAIT with an instruction that wants that converter, also after its result is caught
	assign first_claim_o = (state == ads_pkg::ST_WAIT) && dec.want0
		&& !dec.eoo;
	assign second_claim_o = (state == ads_pkg::ST_WAIT) && dec.want1
		&& !dec.eoo;

	always_comb begin
		next_state = state;
		unique case (state)
			ads_pkg::ST_IDLE: begin
				if (enable_i) begin
					next_state = ads_pkg::ST_FETCH;
				end
			end
			ads_pkg::ST_FETCH: begin
				next_state = ads_pkg::ST_WAIT;
			end
			ads_pkg::ST_WAIT: begin
				// end codes never reach a WORD state
				if (dec.eoo) begin
					next_state = dec.cont ? ads_pkg::ST_FETCH
						: ads_pkg::ST_DONE;
				end else if (have_all) begin
					next_state = ads_pkg::ST_WORD1;
				end
			end
			ads_pkg::ST_WORD1: begin
				if (in_ready) begin
					next_state = dec.two ? ads_pkg::ST_WORD2
						: ads_pkg::ST_FETCH;
				end
			end
			ads_pkg::ST_WORD2: begin
				if (in_ready) begin
					next_state = ads_pkg::ST_FETCH;
				end
			end
			ads_pkg::ST_DONE: begin
				next_state = ads_pkg::ST_DONE;
			end
			default: begin
				next_state = ads_pkg::ST_IDLE;
			end
		endcase
		if (!enable_i) begin
			next_state = ads_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ads_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// continuous flag wraps to entry zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ip <= ads_pkg::PTR_RESET;
		end else if (state == ads_pkg::ST_IDLE) begin
			ip <= ads_pkg::PTR_RESET;
		end else if (state == ads_pkg::ST_WAIT && dec.eoo) begin
			ip <= ads_pkg::PTR_RESET;
		end else if (finish) begin
			ip <= ip + ads_pkg::PTR_STEP;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			instr <= ads_pkg::INSTR_RESET;
		end else if (state == ads_pkg::ST_FETCH) begin
			instr <= store[ip];
		end
	end

	// load on enable, step two bytes per accepted word
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dest <= ads_pkg::ADDR_RESET;
		end else if (state == ads_pkg::ST_IDLE && enable_i) begin
			dest <= start_addr_i;
		end else if (accepted) begin
			dest <= dest + ads_pkg::WORD_BYTES;
		end
	end

	// results are only caught, no conversion is ever started
	// differential result arrives on the first converter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap0 <= 1'b0;
			res0 <= ads_pkg::DATA_RESET;
		end else if (first_claim_o && first_done_i && !cap0) begin
			cap0 <= 1'b1;
			res0 <= first_result_i;
		end else if (finish || state == ads_pkg::ST_IDLE) begin
			cap0 <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap1 <= 1'b0;
			res1 <= ads_pkg::DATA_RESET;
		end else if (second_claim_o && second_done_i && !cap1) begin
			cap1 <= 1'b1;
			res1 <= second_result_i;
		end else if (finish || state == ads_pkg::ST_IDLE) begin
			cap1 <= 1'b0;
		end
	end

	// first word from first register if that converter is wanted, else and second word from second register
	always_comb begin
		word.addr = dest;
		if (state == ads_pkg::ST_WORD1 && dec.want0) begin
			word.data = res0;
		end else begin
			word.data = res1;
		end
	end

	// ****************************************
	// output buffer
	// ****************************************
	// a full buffer holds the sequencer in its WORD state
	ads_fifo #(
		.WIDTH(WW),
		.DEPTH(BUF_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(in_ready),
		.in_data_i(word),
		.out_valid_o(mem_valid_o),
		.out_ready_i(mem_ready_i),
		.out_data_o(out_word)
	);

	assign mem_addr_o = out_word.addr;
	assign mem_data_o = out_word.data;

	// ****************************************
	// checks
	// ****************************************
	// pointer advance
	ptr_advance_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		port_access && !ptr_wr_i |=> wptr == $past(wptr) + ads_pkg::PTR_STEP)
		else $error("write pointer did not advance");

	logic [ads_pkg::PTR_W-1:0] last_ptr;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_ptr <= ads_pkg::PTR_RESET;
		end else begin
			last_ptr <= wptr;
		end
	end

	store_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		port_wr_i |=> store[last_ptr] == $past(port_wdata_i))
		else $error("port write not stored at pointer");

	read_return_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		port_rd_i && !port_wr_i |=> port_rdata_o == store[last_ptr])
		else $error("port read returned wrong entry");

	eoo_no_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		push |-> !dec.eoo)
		else $error("end code produced a memory word");

	cont_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state == ads_pkg::ST_WAIT && dec.eoo && dec.cont && enable_i
		|=> ip == ads_pkg::PTR_RESET && state == ads_pkg::ST_FETCH)
		else $error("continuous end code did not wrap");

	dest_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		accepted |=> dest == $past(dest) + ads_pkg::WORD_BYTES)
		else $error("destination did not step by one word");

	dest_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state == ads_pkg::ST_IDLE && enable_i
		|=> dest == $past(start_addr_i))
		else $error("destination not loaded on enable");

	pair_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state == ads_pkg::ST_WORD1 && in_ready && dec.two && enable_i
		|=> state == ads_pkg::ST_WORD2 && word.data == res1)
		else $error("second word did not follow the first");

	single_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state == ads_pkg::ST_WORD1 && in_ready && !dec.two && enable_i
		|=> state == ads_pkg::ST_FETCH)
		else $error("single instruction wrote more than one word");

	claim_free_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state != ads_pkg::ST_WAIT |-> !first_claim_o && !second_claim_o)
		else $error("converter claimed outside wait");
endmodule

`default_nettype wire

/* File: rtl/ads_pkg.sv */
// Purpose: shared constants and types of the converter transfer sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes: instruction fields and store geometry live here only
`default_nettype none

package ads_pkg;

	// ****************************************
	// store geometry and widths
	// ****************************************
	localparam int STORE_DEPTH = 64;
	localparam int INSTR_W = 8;
	localparam int PTR_W = 6;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;

	// ****************************************
	// instruction fields
	// ****************************************
	localparam int BIT_CONT = 7;
	localparam int BIT_DIFF = 6;
	localparam int BIT_SECOND = 5;
	localparam int BIT_FIRST = 4;
	localparam logic [2:0] REQ_NONE = 3'h0;

	// ****************************************
	// reset values and steps
	// ****************************************
	localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
	localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] WORD_BYTES = 16'h0002;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [INSTR_W-1:0] INSTR_RESET = 8'h00;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_FETCH = 6'b000010,
		ST_WAIT = 6'b000100,
		ST_WORD1 = 6'b001000,
		ST_WORD2 = 6'b010000,
		ST_DONE = 6'b100000
	} ads_state_type;

	typedef struct packed {
		logic eoo;
		logic cont;
		logic want0;
		logic want1;
		logic two;
	} ads_dec_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ads_word_type;

endpackage

`default_nettype wire

/* File: test/ads_partner.sv */
// Purpose: converter pair and data memory model for the sequencer bench
// Assumes: converters are started elsewhere; results hold between pulses
// Notes: results count up per pulse so each stored word is predictable
`default_nettype none

module ads_partner (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic stall_i,
	input wire logic first_claim_i,
	input wire logic second_claim_i,
	output logic first_done_o,
	output logic [ads_pkg::DATA_W-1:0] first_result_o,
	output logic second_done_o,
	output logic [ads_pkg::DATA_W-1:0] second_result_o,
	input wire logic mem_valid_i,
	output logic mem_ready_o,
	input wire logic [ads_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic [ads_pkg::DATA_W-1:0] mem_data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait0;
	logic [3:0] wait1;
	logic [ads_pkg::ADDR_W-1:0] mem_a [64];
	logic [ads_pkg::DATA_W-1:0] mem_d [64];
	int nwords;

	// ****
	// converters
	// ****
	// second converter answers a cycle later to exercise split captures
	assign first_done_o = first_claim_i && wait0 == 4'h2;
	assign second_done_o = second_claim_i && wait1 == 4'h3;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i || clr_i) begin
			wait0 <= 4'h0;
			wait1 <= 4'h0;
			first_result_o <= 16'hA000;
			second_result_o <= 16'hB000;
		end else begin
			wait0 <= !first_claim_i ? 4'h0 : wait0 + {3'h0, wait0 != 4'hF};
			wait1 <= !second_claim_i ? 4'h0 : wait1 + {3'h0, wait1 != 4'hF};
			if (first_done_o)
				first_result_o <= first_result_o + 16'h0001;
			if (second_done_o)
				second_result_o <= second_result_o + 16'h0001;
		end
	end

	// ****
	// data memory
	// ****
	assign mem_ready_o = !stall_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i || clr_i) begin
			nwords <= 0;
		end else if (mem_valid_i && mem_ready_o) begin
			mem_a[nwords[5:0]] <= mem_addr_i;
			mem_d[nwords[5:0]] <= mem_data_i;
			nwords <= nwords + 1;
		end
	end
endmodule

`default_nettype wire

/* File: test/adc_dma_instruction_sequencer_bench.sv */
// Purpose: self-checking bench of the converter transfer sequencer
// Assumes: bench drives inputs 10 ns after each rising edge
// Notes: memory stalls are used to fill the word buffer until it refuses
`default_nettype none

module adc_dma_instruction_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ptr_wr_i = 1'b0;
	logic [5:0] ptr_data_i = 6'h00;
	logic [5:0] wptr;
	logic port_wr_i = 1'b0;
	logic port_rd_i = 1'b0;
	logic [7:0] port_wdata_i = 8'h00;
	logic [7:0] rdata;
	logic enable_i = 1'b0;
	logic [15:0] start_addr_i = 16'h0000;
	logic fdone, sdone, fclaim, sclaim, busy_o, done_o;
	logic [15:0] fres, sres, mem_addr, mem_data;
	logic mem_valid, mem_ready;
	logic clr = 1'b0;
	logic stall = 1'b0;
	int failures = 0;
	int compares = 0;
	localparam logic [7:0] LIST1 [6] = '{8'h90, 8'h20, 8'h30, 8'h40,
		8'h60, 8'h00};
	localparam logic [15:0] EXP1 [7] = '{16'hA000, 16'hB000, 16'hA001,
		16'hB001, 16'hA002, 16'hA003, 16'hB002};

	always #50 clk_i = ~clk_i;

	ads_sequencer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ptr_wr_i(ptr_wr_i), .ptr_data_i(ptr_data_i),
		.instr_write_pointer_o(wptr), .port_wr_i(port_wr_i),
		.port_rd_i(port_rd_i), .port_wdata_i(port_wdata_i),
		.port_rdata_o(rdata), .enable_i(enable_i),
		.start_addr_i(start_addr_i), .first_done_i(fdone),
		.first_result_i(fres), .second_done_i(sdone),
		.second_result_i(sres), .first_claim_o(fclaim),
		.second_claim_o(sclaim), .busy_o(busy_o), .done_o(done_o),
		.mem_valid_o(mem_valid), .mem_ready_i(mem_ready),
		.mem_addr_o(mem_addr), .mem_data_o(mem_data));

	ads_partner u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(clr),
		.stall_i(stall), .first_claim_i(fclaim), .second_claim_i(sclaim),
		.first_done_o(fdone), .first_result_o(fres),
		.second_done_o(sdone), .second_result_o(sres),
		.mem_valid_i(mem_valid), .mem_ready_o(mem_ready),
		.mem_addr_i(mem_addr), .mem_data_i(mem_data));

	// ****
	// helpers
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic tick;
		@(posedge clk_i);
		#10;
	endtask

	task automatic load_ptr(input logic [5:0] p);
		ptr_data_i = p;
		ptr_wr_i = 1'b1;
		tick();
		ptr_wr_i = 1'b0;
		tick();
	endtask

	task automatic port_write(input logic [7:0] b);
		port_wdata_i = b;
		port_wr_i = 1'b1;
		tick();
		port_wr_i = 1'b0;
		tick();
	endtask

	task automatic port_read(input logic [7:0] exp);
		port_rd_i = 1'b1;
		tick();
		port_rd_i = 1'b0;
		tick();
		check({24'h0, rdata}, {24'h0, exp});
	endtask

	// ****
	// scenarios
	// ****
	task automatic store_wrap;
		load_ptr(6'h3E);
		port_write(8'h11);
		port_write(8'h22);
		port_write(8'h33);
		check({26'h0, wptr}, 32'h1);
		load_ptr(6'h3E);
		port_read(8'h11);
		check({26'h0, wptr}, 32'h3F);
		port_read(8'h22);
		port_read(8'h33);
		check({26'h0, wptr}, 32'h1);
	endtask

	task automatic run_list;
		int n;
		load_ptr(6'h00);
		foreach (LIST1[k])
			port_write(LIST1[k]);
		clr = 1'b1;
		tick();
		clr = 1'b0;
		start_addr_i = 16'h0100;
		// converter setup is outside this model and precedes enable
		enable_i = 1'b1;
		for (n = 0; n < 400 && done_o !== 1'b1; n++)
			tick();
		if (n == 400) begin
			failures++;
			test_done();
		end
		check({30'h0, fclaim, sclaim}, 32'h0);
		check({31'h0, done_o}, 32'h1);
		check({31'h0, busy_o}, 32'h0);
		repeat (4) tick();
		check({31'h0, mem_valid}, 32'h0);
		check(u_far.nwords, 7);
		for (int k = 0; k < 7; k++) begin
			check(u_far.mem_a[k], 16'h0100 + 16'(2 * k));
			check(u_far.mem_d[k], EXP1[k]);
		end
		enable_i = 1'b0;
		tick();
	endtask

	task automatic run_cont;
		int n;
		load_ptr(6'h00);
		port_write(8'h30);
		port_write(8'h80);
		clr = 1'b1;
		stall = 1'b1;
		tick();
		clr = 1'b0;
		start_addr_i = 16'h2000;
		enable_i = 1'b1;
		repeat (80) tick();
		// buffer of 8 words full: fifth pair captured, word push refused
		check({31'h0, busy_o}, 32'h1);
		check({31'h0, mem_valid}, 32'h1);
		check(fres, 16'hA005);
		stall = 1'b0;
		for (n = 0; n < 300 && u_far.nwords < 14; n++)
			tick();
		if (n == 300) begin
			failures++;
			test_done();
		end
		enable_i = 1'b0;
		tick();
		tick();
		check({31'h0, busy_o}, 32'h0);
		for (int k = 0; k < 14; k++) begin
			check(u_far.mem_a[k], 16'h2000 + 16'(2 * k));
			check(u_far.mem_d[k], (k % 2 ? 16'hB000 : 16'hA000)
				+ 16'(k / 2));
		end
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		#10;
		rst_n_i = 1'b1;
		check({wptr, rdata, busy_o, done_o, mem_valid}, 32'h0);
		store_wrap();
		run_list();
		run_cont();
		test_done();
	end
endmodule

`default_nettype wire
